// ---- rtf_pkg.sv ----
// Shared constants and types for the resistance to frequency converter
package rtf_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W = 24;
  localparam int FLAG_W = 5;
  localparam int SRC_N = 4;
  localparam int DIVCNT_W = 3;

  // Register word offsets
  localparam logic [3:0] ADDR_CLK = 4'h0;
  localparam logic [3:0] ADDR_CTL = 4'h1;
  localparam logic [3:0] ADDR_TRG = 4'h2;
  localparam logic [3:0] ADDR_MCL = 4'h3;
  localparam logic [3:0] ADDR_MCH = 4'h4;
  localparam logic [3:0] ADDR_TCL = 4'h5;
  localparam logic [3:0] ADDR_TCH = 4'h6;
  localparam logic [3:0] ADDR_INTF = 4'h7;
  localparam logic [3:0] ADDR_INTE = 4'h8;

  // Clock control fields
  localparam int CLK_SRC_LSB = 0;
  localparam int CLK_DIV_LSB = 4;
  localparam int CLK_DEBUG_RUN_BIT = 8;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [1:0] DIV_RST = 2'h0;
  localparam logic DEBUG_RUN_RST = 1'b1;

  // Clock source codes
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_LOW_XTAL = 2'h1;
  localparam logic [1:0] SRC_HIGH_OSC = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // Divider codes and matching tick masks
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_4 = 2'h2;
  localparam logic [1:0] DIV_8 = 2'h3;
  localparam logic [2:0] MASK_1 = 3'h0;
  localparam logic [2:0] MASK_2 = 3'h1;
  localparam logic [2:0] MASK_4 = 3'h3;
  localparam logic [2:0] MASK_8 = 3'h7;

  // Channel control fields
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_EVT_BIT = 6;
  localparam logic [1:0] MODE_DC = 2'h0;
  localparam logic [1:0] MODE_AC = 2'h1;
  localparam logic [1:0] MODE_RST = 2'h0;

  // Trigger bits
  localparam int TRG_REF_BIT = 0;
  localparam int TRG_SENA_BIT = 1;
  localparam int TRG_SENB_BIT = 2;

  // Flag and enable bits
  localparam int FL_REF_DONE = 0;
  localparam int FL_SENA_DONE = 1;
  localparam int FL_SENB_DONE = 2;
  localparam int FL_MEAS_OVF = 3;
  localparam int FL_TB_OVF = 4;

  localparam logic [23:0] CNT_ZERO = 24'h000000;
  localparam logic [23:0] CNT_ONE = 24'h000001;
  localparam logic [23:0] CNT_ONES = 24'hffffff;
  localparam int CNT_LO_W = 16;
  localparam int CNT_HI_W = 8;

  // One-hot phase bit positions
  localparam int PH_IDLE_BIT = 0;
  localparam int PH_REF_BIT = 1;
  localparam int PH_SENA_BIT = 2;
  localparam int PH_SENB_BIT = 3;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_REF = 4'b0010,
    PH_SENA = 4'b0100,
    PH_SENB = 4'b1000
  } rtf_phase_t;

endpackage

// ---- rtf_edge_sync.sv ----
// Two-stage synchroniser with registered rising edge detect
`timescale 1ns/1ps
module rtf_edge_sync #(
  parameter int N = 1
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic [N-1:0] din, // Asynchronous pin levels
  output logic [N-1:0] rise // One-cycle pulse per rising edge
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] rise;
  } rtf_sync_state_t;

  rtf_sync_state_t s_reg;
  rtf_sync_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.s1 = din;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.rise = s_reg.s2 & ~s_reg.s3;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rise = s_reg.rise;

endmodule

// ---- rtf_converter.sv ----
// Resistance to frequency converter channel with register port
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module rtf_converter #(
  parameter logic [3:0] SRC_SUPPORTED = 4'hf // Usable clock sources
) (
  input wire logic clk, // 200 MHz system clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [3:0] addr, // Register word address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after read strobe
  input wire logic osc_clk_in, // CR oscillation feedback pin
  input wire logic ext_clk_in, // External event pulse pin
  input wire logic [3:0] src_clk_in, // Operating clock sources by code
  input wire logic debug_mode, // CPU in debug mode
  output logic irq, // Interrupt request, active high
  output logic ref_drive, // Reference oscillation running
  output logic sena_drive, // Sensor A oscillation running
  output logic senb_drive, // Sensor B oscillation running
  output logic [1:0] osc_mode, // Drive mode to oscillator
  output logic event_mode // External pulse counting selected
);

  typedef struct packed {
    logic [1:0] src;
    logic [1:0] div;
    logic debug_run;
    logic en;
    logic [1:0] mode;
    logic evt;
    rtf_pkg::rtf_phase_t phase;
    logic [23:0] mc;
    logic [23:0] tc;
    logic [4:0] flags;
    logic [4:0] inte;
    logic [2:0] divcnt;
    logic [15:0] rdata;
    logic irq;
  } rtf_state_t;

  localparam rtf_state_t STATE_RST = '{
    src: rtf_pkg::SRC_RST,
    div: rtf_pkg::DIV_RST,
    debug_run: rtf_pkg::DEBUG_RUN_RST,
    en: 1'b0,
    mode: rtf_pkg::MODE_RST,
    evt: 1'b0,
    phase: rtf_pkg::PH_IDLE,
    mc: rtf_pkg::CNT_ZERO,
    tc: rtf_pkg::CNT_ZERO,
    flags: 5'h00,
    inte: 5'h00,
    divcnt: 3'h0,
    rdata: 16'h0000,
    irq: 1'b0
  };

  rtf_state_t s_reg;
  rtf_state_t s_next;

  logic rst_meta_reg;
  logic rst_sync_reg;

  // Release reset through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic [5:0] pin_rise;

  rtf_edge_sync #(
    .N(6)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_sync_reg),
    .din({ext_clk_in, osc_clk_in, src_clk_in}),
    .rise(pin_rise)
  );

  logic [3:0] src_rise;
  logic osc_rise;
  logic ext_rise;
  logic meas_tick;
  logic src_tick;
  logic clock_run;
  logic undivided;
  logic [2:0] div_mask;
  logic op_tick;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic stop;
  logic [1:0] wsrc;

  assign src_rise = pin_rise[3:0];
  assign osc_rise = pin_rise[4];
  assign ext_rise = pin_rise[5];
  assign meas_tick = s_reg.evt ? ext_rise : osc_rise;
  assign src_tick = src_rise[s_reg.src];
  assign clock_run = s_reg.debug_run | ~debug_mode;
  assign undivided = (s_reg.src == rtf_pkg::SRC_LOW_XTAL) ||
                     (s_reg.src == rtf_pkg::SRC_EXT);
  assign wsrc = wdata[rtf_pkg::CLK_SRC_LSB +: 2];

  // Divide ratio as a tick mask on the divider count
  always_comb begin
    case (s_reg.div)
      rtf_pkg::DIV_1: div_mask = rtf_pkg::MASK_1;
      rtf_pkg::DIV_2: div_mask = rtf_pkg::MASK_2;
      rtf_pkg::DIV_4: div_mask = rtf_pkg::MASK_4;
      rtf_pkg::DIV_8: div_mask = rtf_pkg::MASK_8;
      default: div_mask = rtf_pkg::MASK_1;
    endcase
  end

  // Operating clock tick, gated by enable and debug stop
  assign op_tick = s_reg.en & clock_run & src_tick &
                   (undivided | ((s_reg.divcnt & div_mask) == div_mask));

  always_comb begin
    s_next = s_reg;
    flag_set = 5'h00;
    flag_clr = 5'h00;
    stop = 1'b0;

    // Divider count runs only while the clock is supplied
    if (!s_reg.en) begin
      s_next.divcnt = 3'h0;
    end else if (clock_run && src_tick) begin
      s_next.divcnt = s_reg.divcnt + 3'h1;
    end

    case (s_reg.phase)
      rtf_pkg::PH_IDLE: begin
      end
      rtf_pkg::PH_REF: begin
        if (meas_tick) begin
          if (s_reg.mc == rtf_pkg::CNT_ONES) begin
            s_next.mc = rtf_pkg::CNT_ZERO;
            flag_set[rtf_pkg::FL_REF_DONE] = 1'b1;
            stop = 1'b1;
          end else begin
            s_next.mc = s_reg.mc + rtf_pkg::CNT_ONE;
          end
        end
        if (op_tick) begin
          if (s_reg.tc == rtf_pkg::CNT_ONES) begin
            s_next.tc = rtf_pkg::CNT_ZERO;
            flag_set[rtf_pkg::FL_TB_OVF] = 1'b1;
            stop = 1'b1;
          end else begin
            s_next.tc = s_reg.tc + rtf_pkg::CNT_ONE;
          end
        end
      end
      rtf_pkg::PH_SENA, rtf_pkg::PH_SENB: begin
        if (meas_tick) begin
          if (s_reg.mc == rtf_pkg::CNT_ONES) begin
            s_next.mc = rtf_pkg::CNT_ZERO;
            flag_set[rtf_pkg::FL_MEAS_OVF] = 1'b1;
            stop = 1'b1;
          end else begin
            s_next.mc = s_reg.mc + rtf_pkg::CNT_ONE;
          end
        end
        if (op_tick) begin
          // A zero start value ends on the first tick instead of wrapping
          if (s_reg.tc <= rtf_pkg::CNT_ONE) begin
            s_next.tc = rtf_pkg::CNT_ZERO;
            if (s_reg.phase == rtf_pkg::PH_SENA) begin
              flag_set[rtf_pkg::FL_SENA_DONE] = 1'b1;
            end else begin
              flag_set[rtf_pkg::FL_SENB_DONE] = 1'b1;
            end
            stop = 1'b1;
          end else begin
            s_next.tc = s_reg.tc - rtf_pkg::CNT_ONE;
          end
        end
      end
      default: begin
        stop = 1'b1;
      end
    endcase

    if (stop) begin
      s_next.phase = rtf_pkg::PH_IDLE;
    end

    if (wr) begin
      case (addr)
        rtf_pkg::ADDR_CLK: begin
          if (!s_reg.en) begin
            s_next.debug_run = wdata[rtf_pkg::CLK_DEBUG_RUN_BIT];
            if (SRC_SUPPORTED[wsrc]) begin
              s_next.src = wsrc;
              if ((wsrc == rtf_pkg::SRC_LOW_XTAL) ||
                  (wsrc == rtf_pkg::SRC_EXT)) begin
                s_next.div = rtf_pkg::DIV_8;
              end else begin
                s_next.div = wdata[rtf_pkg::CLK_DIV_LSB +: 2];
              end
            end
          end
        end
        rtf_pkg::ADDR_CTL: begin
          s_next.en = wdata[rtf_pkg::CTL_EN_BIT];
          s_next.mode = wdata[rtf_pkg::CTL_MODE_LSB +: 2];
          s_next.evt = wdata[rtf_pkg::CTL_EVT_BIT];
        end
        rtf_pkg::ADDR_TRG: begin
          if (s_reg.en) begin
            if (s_reg.phase != rtf_pkg::PH_IDLE) begin
              // Abort leaves both counters where they stopped
              if ((s_reg.phase == rtf_pkg::PH_REF &&
                   !wdata[rtf_pkg::TRG_REF_BIT]) ||
                  (s_reg.phase == rtf_pkg::PH_SENA &&
                   !wdata[rtf_pkg::TRG_SENA_BIT]) ||
                  (s_reg.phase == rtf_pkg::PH_SENB &&
                   !wdata[rtf_pkg::TRG_SENB_BIT])) begin
                s_next.phase = rtf_pkg::PH_IDLE;
                s_next.mc = s_reg.mc;
                s_next.tc = s_reg.tc;
              end
            end else if (wdata[rtf_pkg::TRG_REF_BIT]) begin
              s_next.phase = rtf_pkg::PH_REF;
              s_next.tc = rtf_pkg::CNT_ZERO;
            end else if (wdata[rtf_pkg::TRG_SENA_BIT]) begin
              s_next.phase = rtf_pkg::PH_SENA;
              s_next.mc = rtf_pkg::CNT_ZERO;
            end else if (wdata[rtf_pkg::TRG_SENB_BIT] &&
                         s_reg.mode != rtf_pkg::MODE_AC) begin
              s_next.phase = rtf_pkg::PH_SENB;
              s_next.mc = rtf_pkg::CNT_ZERO;
            end
          end
        end
        rtf_pkg::ADDR_MCL: begin
          s_next.mc[rtf_pkg::CNT_LO_W-1:0] = wdata;
        end
        rtf_pkg::ADDR_MCH: begin
          s_next.mc[rtf_pkg::CNT_W-1:rtf_pkg::CNT_LO_W] =
            wdata[rtf_pkg::CNT_HI_W-1:0];
        end
        rtf_pkg::ADDR_TCL: begin
          s_next.tc[rtf_pkg::CNT_LO_W-1:0] = wdata;
        end
        rtf_pkg::ADDR_TCH: begin
          s_next.tc[rtf_pkg::CNT_W-1:rtf_pkg::CNT_LO_W] =
            wdata[rtf_pkg::CNT_HI_W-1:0];
        end
        rtf_pkg::ADDR_INTF: begin
          flag_clr = wdata[rtf_pkg::FLAG_W-1:0];
        end
        rtf_pkg::ADDR_INTE: begin
          s_next.inte = wdata[rtf_pkg::FLAG_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Disabling the channel ends any conversion in progress
    if (!s_next.en) begin
      s_next.phase = rtf_pkg::PH_IDLE;
    end

    // Hardware set wins over a same-cycle clear
    s_next.flags = (s_reg.flags & ~flag_clr) | flag_set;
    s_next.irq = |(s_next.flags & s_next.inte);

    s_next.rdata = 16'h0000;
    if (rd) begin
      case (addr)
        rtf_pkg::ADDR_CLK: begin
          s_next.rdata[rtf_pkg::CLK_SRC_LSB +: 2] = s_reg.src;
          s_next.rdata[rtf_pkg::CLK_DIV_LSB +: 2] = s_reg.div;
          s_next.rdata[rtf_pkg::CLK_DEBUG_RUN_BIT] = s_reg.debug_run;
        end
        rtf_pkg::ADDR_CTL: begin
          s_next.rdata[rtf_pkg::CTL_EN_BIT] = s_reg.en;
          s_next.rdata[rtf_pkg::CTL_MODE_LSB +: 2] = s_reg.mode;
          s_next.rdata[rtf_pkg::CTL_EVT_BIT] = s_reg.evt;
        end
        rtf_pkg::ADDR_TRG: begin
          s_next.rdata[rtf_pkg::TRG_REF_BIT] =
            s_reg.phase[rtf_pkg::PH_REF_BIT];
          s_next.rdata[rtf_pkg::TRG_SENA_BIT] =
            s_reg.phase[rtf_pkg::PH_SENA_BIT];
          s_next.rdata[rtf_pkg::TRG_SENB_BIT] =
            s_reg.phase[rtf_pkg::PH_SENB_BIT];
        end
        rtf_pkg::ADDR_MCL: begin
          s_next.rdata = s_reg.mc[rtf_pkg::CNT_LO_W-1:0];
        end
        rtf_pkg::ADDR_MCH: begin
          s_next.rdata[rtf_pkg::CNT_HI_W-1:0] =
            s_reg.mc[rtf_pkg::CNT_W-1:rtf_pkg::CNT_LO_W];
        end
        rtf_pkg::ADDR_TCL: begin
          s_next.rdata = s_reg.tc[rtf_pkg::CNT_LO_W-1:0];
        end
        rtf_pkg::ADDR_TCH: begin
          s_next.rdata[rtf_pkg::CNT_HI_W-1:0] =
            s_reg.tc[rtf_pkg::CNT_W-1:rtf_pkg::CNT_LO_W];
        end
        rtf_pkg::ADDR_INTF: begin
          s_next.rdata[rtf_pkg::FLAG_W-1:0] = s_reg.flags;
        end
        rtf_pkg::ADDR_INTE: begin
          s_next.rdata[rtf_pkg::FLAG_W-1:0] = s_reg.inte;
        end
        default: begin
          s_next.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign ref_drive = s_reg.phase[rtf_pkg::PH_REF_BIT];
  assign sena_drive = s_reg.phase[rtf_pkg::PH_SENA_BIT];
  assign senb_drive = s_reg.phase[rtf_pkg::PH_SENB_BIT];
  assign osc_mode = s_reg.mode;
  assign event_mode = s_reg.evt;

endmodule

// ---- rtf_converter_asserts.sv ----
// Port-level concurrent checks for the converter channel
`timescale 1ns/1ps
module rtf_converter_asserts (
  input wire logic clk, // System clock
  input wire logic resetn, // Reset, active low
  input wire logic [3:0] addr, // Register address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [15:0] rdata, // Read data
  input wire logic irq, // Interrupt request
  input wire logic ref_drive, // Reference running
  input wire logic sena_drive, // Sensor A running
  input wire logic senb_drive, // Sensor B running
  input wire logic [1:0] osc_mode, // Drive mode
  input wire logic event_mode // Event counting
);
  logic en_reg;
  logic en_next;
  logic idle;
  logic trg_wr;

  assign idle = !(ref_drive | sena_drive | senb_drive);
  assign trg_wr = wr && addr == rtf_pkg::ADDR_TRG;

  // Shadow of the channel enable bit
  always_comb begin
    en_next = en_reg;
    if (wr && addr == rtf_pkg::ADDR_CTL) begin
      en_next = wdata[rtf_pkg::CTL_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_one_phase: assert property (
    $onehot0({ref_drive, sena_drive, senb_drive}))
    else $error("more than one phase running");
  a_ref_start: assert property (
    en_reg && idle && trg_wr && wdata[0] |=> ref_drive)
    else $error("reference start not taken");
  a_abort_stop: assert property (
    ref_drive && trg_wr && !wdata[0] |=> !ref_drive)
    else $error("abort did not stop reference");
  a_trg_status: assert property (
    rd && addr == rtf_pkg::ADDR_TRG |=>
    rdata == {13'h0, $past({senb_drive, sena_drive, ref_drive})})
    else $error("start bits do not show running phase");
  a_trg_locked: assert property (
    !en_reg && idle && trg_wr |=> idle)
    else $error("start taken while disabled");
  a_no_b_ac: assert property (
    idle && trg_wr && wdata[2:0] == 3'b100 &&
    osc_mode == rtf_pkg::MODE_AC |=> idle)
    else $error("sensor B started in AC mode");
  a_mode_copy: assert property (
    wr && addr == rtf_pkg::ADDR_CTL && !wdata[5] |=>
    osc_mode == $past(wdata[5:4]))
    else $error("drive mode not following control");
  a_event_copy: assert property (
    wr && addr == rtf_pkg::ADDR_CTL |=> event_mode == $past(wdata[6]))
    else $error("event mode not following control");
  a_irq_masked: assert property (
    wr && addr == rtf_pkg::ADDR_INTE && wdata[4:0] == 5'h00 |=> ##1 !irq)
    else $error("request while all enables zero");

  c_ref_end: cover property (ref_drive ##1 !ref_drive);
  c_sena_end: cover property (sena_drive ##1 !sena_drive);
  c_senb_end: cover property (senb_drive ##1 !senb_drive);
  c_irq_rise: cover property ($rose(irq));
endmodule

bind rtf_converter rtf_converter_asserts u_rtf_converter_asserts (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .irq(irq), .ref_drive(ref_drive),
  .sena_drive(sena_drive), .senb_drive(senb_drive),
  .osc_mode(osc_mode), .event_mode(event_mode));

// ---- rtf_osc_model.sv ----
// Behavioural CR oscillator seen on the feedback pin
`timescale 1ns/1ps
module rtf_osc_model (
  input wire logic run, // Any drive enabled
  input wire logic slow, // Long oscillation period
  output logic osc_clk_in // Oscillation feedback pin
);
  // Pin returns low at the end of the current half period once no drive is on
  initial begin
    osc_clk_in = 1'b0;
    forever begin
      wait (run);
      #(slow ? 60 : 20);
      osc_clk_in = run & ~osc_clk_in;
    end
  end
endmodule

// ---- tb_rtf_converter.sv ----
// Self-checking testbench for the converter channel
`timescale 1ns/1ps
module tb_rtf_converter;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic debug_mode = 1'b0;
  logic ext_clk_in = 1'b0;
  logic slow = 1'b0;
  logic pend = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] src_clk_in = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, got, h;
  logic osc_clk_in, irq, ref_drive, sena_drive, senb_drive, event_mode;
  logic [1:0] osc_mode;
  logic [31:0] expq[$];
  logic [31:0] e;
  int errors = 0;
  int checks_done = 0;
  int seed = 32'h196a891a;

  always #2.5 clk = ~clk;
  always #7 src_clk_in[0] = ~src_clk_in[0];
  always #26 src_clk_in[1] = ~src_clk_in[1];

  rtf_converter #(.SRC_SUPPORTED(4'h7)) u_rtf_converter (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .osc_clk_in(osc_clk_in),
    .ext_clk_in(ext_clk_in), .src_clk_in(src_clk_in),
    .debug_mode(debug_mode), .irq(irq), .ref_drive(ref_drive),
    .sena_drive(sena_drive), .senb_drive(senb_drive),
    .osc_mode(osc_mode), .event_mode(event_mode));

  rtf_osc_model u_rtf_osc_model (
    .run(ref_drive | sena_drive | senb_drive), .slow(slow),
    .osc_clk_in(osc_clk_in));

  task automatic finish_test;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic bad(input string m);
    errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  task automatic chk(input logic g, input logic x);
    #1;
    checks_done++;
    if (g !== x) bad("output level");
  endtask

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Let the registered outputs settle before callers look
    #1;
  endtask

  // Mask of zero only fetches the value into got
  task automatic rreg(input logic [3:0] a, input logic [15:0] x,
                      input logic [15:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back({m, x});
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  always @(posedge clk) begin
    if (pend && expq.size() > 0) begin
      e = expq.pop_front();
      if (e[31:16] != 16'h0000) begin
        checks_done++;
        if ((rdata & e[31:16]) !== (e[15:0] & e[31:16])) bad("read data");
      end
    end
    pend <= rd;
  end

  task automatic wait_idle;
    int n = 0;
    @(posedge clk);
    #1;
    while ((ref_drive | sena_drive | senb_drive) !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 5000) begin
        bad("phase never ended");
        finish_test;
      end
    end
  endtask

  task automatic ref_run;
    int r;
    r = $random(seed);
    wreg(rtf_pkg::ADDR_MCL, {12'hfff, r[3:0]});
    wreg(rtf_pkg::ADDR_MCH, 16'h00ff);
    wreg(rtf_pkg::ADDR_TRG, 16'h0001);
    rreg(rtf_pkg::ADDR_TRG, 16'h0001, 16'hffff);
    wait_idle;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rreg(rtf_pkg::ADDR_CLK, 16'h0100, 16'hffff);
    rreg(rtf_pkg::ADDR_CTL, 16'h0000, 16'hffff);
    rreg(4'hf, 16'h0000, 16'hffff);
    wreg(rtf_pkg::ADDR_CLK, 16'h0103);
    rreg(rtf_pkg::ADDR_CLK, 16'h0100, 16'hffff);
    wreg(rtf_pkg::ADDR_CLK, 16'h0101);
    rreg(rtf_pkg::ADDR_CLK, 16'h0131, 16'hffff);
    for (int d = 0; d < 4; d++) begin
      wreg(rtf_pkg::ADDR_CLK, 16'h0002 | 16'(d << 4));
      rreg(rtf_pkg::ADDR_CLK, 16'h0002 | 16'(d << 4), 16'hffff);
    end
    wreg(rtf_pkg::ADDR_CLK, 16'h0000);
    wreg(rtf_pkg::ADDR_INTE, 16'h001f);
    wreg(rtf_pkg::ADDR_CTL, 16'h0001);
    wreg(rtf_pkg::ADDR_CLK, 16'h0022);
    rreg(rtf_pkg::ADDR_CLK, 16'h0000, 16'hffff);
    debug_mode <= 1'b1;
    ref_run();
    rreg(rtf_pkg::ADDR_TCL, 16'h0000, 16'hffff);
    debug_mode <= 1'b0;
    rreg(rtf_pkg::ADDR_INTF, 16'h0001, 16'hffff);
    chk(irq, 1'b1);
    wreg(rtf_pkg::ADDR_INTF, 16'h0000);
    rreg(rtf_pkg::ADDR_INTF, 16'h0001, 16'hffff);
    wreg(rtf_pkg::ADDR_INTF, 16'h0001);
    rreg(rtf_pkg::ADDR_INTF, 16'h0000, 16'hffff);
    chk(irq, 1'b0);
    ref_run();
    rreg(rtf_pkg::ADDR_TRG, 16'h0000, 16'hffff);
    wreg(rtf_pkg::ADDR_INTF, 16'h001f);
    slow <= 1'b1;
    wreg(rtf_pkg::ADDR_TRG, 16'h0002);
    wait_idle;
    rreg(rtf_pkg::ADDR_INTF, 16'h0002, 16'hffff);
    rreg(rtf_pkg::ADDR_TCL, 16'h0000, 16'hffff);
    rreg(rtf_pkg::ADDR_MCH, 16'h0000, 16'hffff);
    slow <= 1'b0;
    wreg(rtf_pkg::ADDR_INTF, 16'h001f);
    wreg(rtf_pkg::ADDR_TCH, 16'h00ff);
    wreg(rtf_pkg::ADDR_TRG, 16'h0004);
    wreg(rtf_pkg::ADDR_MCH, 16'h00ff);
    wreg(rtf_pkg::ADDR_MCL, 16'hfff8);
    wait_idle;
    rreg(rtf_pkg::ADDR_INTF, 16'h0008, 16'hffff);
    rreg(rtf_pkg::ADDR_TRG, 16'h0000, 16'hffff);
    wreg(rtf_pkg::ADDR_INTF, 16'h001f);
    wreg(rtf_pkg::ADDR_MCL, 16'h0000);
    wreg(rtf_pkg::ADDR_MCH, 16'h0000);
    wreg(rtf_pkg::ADDR_TRG, 16'h0001);
    wreg(rtf_pkg::ADDR_TCH, 16'h00ff);
    wreg(rtf_pkg::ADDR_TCL, 16'hfff0);
    wait_idle;
    rreg(rtf_pkg::ADDR_INTF, 16'h0010, 16'hffff);
    wreg(rtf_pkg::ADDR_INTE, 16'h0000);
    chk(irq, 1'b0);
    wreg(rtf_pkg::ADDR_INTE, 16'h0010);
    chk(irq, 1'b1);
    wreg(rtf_pkg::ADDR_INTF, 16'h001f);
    wreg(rtf_pkg::ADDR_TRG, 16'h0001);
    repeat (20) @(posedge clk);
    wreg(rtf_pkg::ADDR_TRG, 16'h0000);
    chk(ref_drive, 1'b0);
    rreg(rtf_pkg::ADDR_TCL, 16'h0000, 16'h0000);
    h = got;
    repeat (20) @(posedge clk);
    rreg(rtf_pkg::ADDR_TCL, h, 16'hffff);
    rreg(rtf_pkg::ADDR_INTF, 16'h0000, 16'hffff);
    wreg(rtf_pkg::ADDR_CTL, 16'h0011);
    chk(osc_mode === rtf_pkg::MODE_AC, 1'b1);
    wreg(rtf_pkg::ADDR_TRG, 16'h0004);
    rreg(rtf_pkg::ADDR_TRG, 16'h0000, 16'hffff);
    wreg(rtf_pkg::ADDR_CTL, 16'h0040);
    chk(event_mode, 1'b1);
    wreg(rtf_pkg::ADDR_TRG, 16'h0001);
    rreg(rtf_pkg::ADDR_TRG, 16'h0000, 16'hffff);
    // Event mode: only external pulses may reach the measure counter
    slow <= 1'b1;
    wreg(rtf_pkg::ADDR_CTL, 16'h0041);
    wreg(rtf_pkg::ADDR_MCL, 16'h0000);
    wreg(rtf_pkg::ADDR_MCH, 16'h0000);
    wreg(rtf_pkg::ADDR_TRG, 16'h0001);
    repeat (3) begin
      repeat (3) @(posedge clk);
      ext_clk_in <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clk_in <= 1'b0;
    end
    repeat (6) @(posedge clk);
    wreg(rtf_pkg::ADDR_TRG, 16'h0000);
    rreg(rtf_pkg::ADDR_MCL, 16'h0003, 16'hffff);
    repeat (2) @(posedge clk);
    finish_test;
  end
endmodule
